// File: inc/lavsr_link_if.sv
/*
  Interface carrying synchronised SPI link events from the link front end
  to the status register core.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface lavsr_link_if;
  logic frameStart;
  logic frameEnd;
  logic sclkRise;
  logic sclkFall;
  logic sdiBit;
  logic csActive;
  modport front (output frameStart, output frameEnd, output sclkRise, output sclkFall,
    output sdiBit, output csActive);
  modport core (input frameStart, input frameEnd, input sclkRise, input sclkFall,
    input sdiBit, input csActive);
endinterface : lavsr_link_if
`default_nettype wire

// File: inc/lavsr_pkg.sv
/*
  Package for the limit violation status register block: layout, reset values,
  SPI frame fields and variant constants.
  Assumes a 40 MHz core clock and a 16-bit SPI frame, mode 0.
*/
package lavsr_pkg;
  // Flag layout
  localparam int NUM_CH = 8;
  localparam int FLAG_W = 16;
  localparam int OVER_BIT_OFS = 0;
  localparam int UNDER_BIT_OFS = 1;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  // Channel limits and comparison
  localparam int LIMIT_W = 9;
  localparam int RESULT_W = 12;
  localparam logic [2:0] LOW_PAD = 3'h0;
  localparam logic [2:0] HIGH_PAD = 3'h7;
  // Command frame fields
  localparam int FRAME_W = 16;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 11;
  localparam int WRITE_SEL_BIT = 10;
  localparam logic [4:0] FLAGS_ADDR = 5'h02;
  // Serial clock edge on which the read clear lands
  localparam logic [4:0] CLEAR_EDGE = 5'h02;
  // Variant masks: channels present in the 2-, 4- and 8-channel parts
  localparam logic [15:0] MASK_2CH = 16'h000f;
  localparam logic [15:0] MASK_4CH = 16'h00ff;
  localparam logic [15:0] MASK_8CH = 16'hffff;
  typedef enum logic [1:0] {LAVSR_VAR2, LAVSR_VAR4, LAVSR_VAR8} lavsr_variant_t;
endpackage : lavsr_pkg

// File: rtl/lavsr_link_sync.sv
/*
  SPI pin synchroniser and edge finder.
  Assumes SCLK, CS and SDI come from outside the core_clk domain, SCLK well
  below a quarter of core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lavsr_link_sync (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sclkPin,
  input wire logic csPin_n,
  input wire logic sdiPin,
  lavsr_link_if.front link
);
  logic [1:0] sclkSync_q;
  logic [1:0] csSync_q;
  logic [1:0] sdiSync_q;
  logic sclkLast_q;
  logic csLast_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers and history for edge detection
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkSync_q <= 2'h0;
      csSync_q <= 2'h3;
      sdiSync_q <= 2'h0;
      sclkLast_q <= 1'b0;
      csLast_q <= 1'b1;
    end else begin
      sclkSync_q <= {sclkSync_q[0], sclkPin};
      csSync_q <= {csSync_q[0], csPin_n};
      sdiSync_q <= {sdiSync_q[0], sdiPin};
      sclkLast_q <= sclkSync_q[1];
      csLast_q <= csSync_q[1];
    end
  end

  // Edges seen only while framed; SCLK outside a frame is ignored
  assign link.csActive = !csSync_q[1];
  assign link.frameStart = csLast_q && !csSync_q[1];
  assign link.frameEnd = !csLast_q && csSync_q[1];
  assign link.sclkRise = !csSync_q[1] && !sclkLast_q && sclkSync_q[1];
  assign link.sclkFall = !csSync_q[1] && sclkLast_q && !sclkSync_q[1];
  assign link.sdiBit = sdiSync_q[1];
endmodule : lavsr_link_sync
`default_nettype wire

// File: rtl/lavsr_status_reg.sv
/*
  Limit violation status register with SPI read-out and read clear.
  Assumes conversion results arrive as a one-cycle strobe on core_clk with a
  channel number; limits come from the configuration store as plain inputs.
*/
// Function
// - Sixteen-bit status register, read only; writes never change it.
// - Two flags per channel: upper-limit and lower-limit violation.
// - Channel n upper flag at bit 2n, lower flag at bit 2n+1.
// - Flag one means violation recorded; zero means none recorded.
// - New violations set further flags; earlier flags kept until read.
// - Reading clears all flags at second serial clock of read-out frame.
// - Conversion completing before read-out sends result instead of flags.
// - Pre-empted read-out leaves every flag unchanged, no clear.
// - Flags of absent channels in smaller variants always read zero.
// - All flags reset to zero.
// - Lower flag set below low limit; upper flag set above high limit.
// - Nine-bit limits padded: low with 000, high with 111.
// - Soft reset bit clears flags and result, leaves configuration.
`timescale 1ns/1ps
`default_nettype none
module lavsr_status_reg (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] variantSel,
  input wire logic sclkPin,
  input wire logic csPin_n,
  input wire logic sdiPin,
  input wire logic convDone,
  input wire logic [2:0] convChannel,
  input wire logic [11:0] convResult,
  input wire logic [71:0] lowLimits,
  input wire logic [71:0] highLimits,
  input wire logic softResetReq,
  output logic sdoOut,
  output logic sdoOe_n,
  output logic [15:0] flagsView,
  output logic [11:0] resultView,
  output logic multifunction_event_pin
);
  lavsr_link_if link ();

  lavsr_link_sync lavsr_link_sync_inst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sclkPin(sclkPin),
    .csPin_n(csPin_n),
    .sdiPin(sdiPin),
    .link(link.front)
  );

  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic [11:0] result_q;
  logic [15:0] shiftIn_q;
  logic [4:0] bitCnt_q;
  logic readPending_q;
  logic readPending_d;
  logic preempt_q;
  logic preempt_d;
  logic frameIsFlags_q;
  logic [15:0] shiftOut_q;
  logic [15:0] shiftOut_d;
  logic sdo_q;
  logic sdoOe_q;
  logic softRst_q;
  logic [15:0] variantMask;
  logic [15:0] violSet;
  logic clearNow;
  logic cmdDone;
  logic cmdIsFlagRead;
  logic [15:0] cmdWord;
  logic [4:0] cmdAddr;
  logic cmdWriteSel;
  logic [11:0] hiLimit;
  logic [11:0] loLimit;
  logic overLimit;
  logic underLimit;
  logic flagsSelected;
  logic evtPin_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Padded limit values for one channel
  function automatic logic [11:0] padLimit(input logic [71:0] lims, input logic [2:0] ch,
      input logic [2:0] pad);
    padLimit = {lims[ch * lavsr_pkg::LIMIT_W +: lavsr_pkg::LIMIT_W], pad};
  endfunction : padLimit

  // Mask of implemented channels
  assign variantMask = (variantSel == 2'(lavsr_pkg::LAVSR_VAR2)) ? lavsr_pkg::MASK_2CH :
    (variantSel == 2'(lavsr_pkg::LAVSR_VAR4)) ? lavsr_pkg::MASK_4CH :
    lavsr_pkg::MASK_8CH;

  // Padded limits for the channel just converted
  assign hiLimit = padLimit(highLimits, convChannel, lavsr_pkg::HIGH_PAD);
  assign loLimit = padLimit(lowLimits, convChannel, lavsr_pkg::LOW_PAD);
  // Strict compares: a result equal to a limit is no violation
  assign overLimit = convResult > hiLimit;
  assign underLimit = convResult < loLimit;

  // Flag bits raised by the conversion in this cycle
  always_comb begin
    violSet = 16'h0000;
    if (convDone) begin
      violSet[{convChannel, 1'b0} + 4'(lavsr_pkg::OVER_BIT_OFS)] = overLimit;
      violSet[{convChannel, 1'b0} + 4'(lavsr_pkg::UNDER_BIT_OFS)] = underLimit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode: a read of the flags register (write-select zero)
  assign cmdDone = link.sclkRise && (bitCnt_q == 5'(lavsr_pkg::FRAME_W - 1));
  // Command word as it stands once its last bit is shifted in
  assign cmdWord = {shiftIn_q[14:0], link.sdiBit};
  assign cmdAddr = cmdWord[lavsr_pkg::ADDR_MSB:lavsr_pkg::ADDR_LSB];
  assign cmdWriteSel = cmdWord[lavsr_pkg::WRITE_SEL_BIT];
  // Writes fall through here, so no command can ever load the flags
  assign cmdIsFlagRead = (cmdAddr == lavsr_pkg::FLAGS_ADDR) && !cmdWriteSel;
  // Clear on the second serial clock of a flag read-out frame, unless pre-empted
  assign clearNow = frameIsFlags_q && link.sclkRise &&
    (bitCnt_q == lavsr_pkg::CLEAR_EDGE - 5'h1);

  // Flag update: set beats clear, sets accumulate
  // Soft reset wins over both, nothing survives it
  always_comb begin
    flags_d = flags_q | violSet;
    if (softRst_q) begin
      flags_d = lavsr_pkg::FLAGS_RST;
    end else if (clearNow) begin
      flags_d = violSet;
    end
    flags_d = flags_d & variantMask;
  end

  // Read pending and pre-emption tracking between command and read-out frame
  always_comb begin
    readPending_d = readPending_q;
    preempt_d = preempt_q;
    if (link.frameStart) begin
      readPending_d = 1'b0;
      preempt_d = 1'b0;
    end else if (cmdDone) begin
      readPending_d = cmdIsFlagRead;
    end else if (convDone && readPending_q) begin
      preempt_d = 1'b1;
    end
  end

  // Read-out frame carries flags only if no conversion came in between
  assign flagsSelected = readPending_q && !preempt_q;

  // Output shifter load: flags, or result when a conversion pre-empted the read
  always_comb begin
    shiftOut_d = shiftOut_q;
    if (link.frameStart) begin
      shiftOut_d = flagsSelected ? (flags_q & variantMask) : {4'h0, result_q};
    end else if (link.sclkFall) begin
      shiftOut_d = {shiftOut_q[14:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flag and result storage
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= lavsr_pkg::FLAGS_RST;
      result_q <= 12'h000;
      softRst_q <= 1'b0;
      evtPin_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      // Pin follows the next flag value, so it moves with flagsView
      evtPin_q <= |flags_d;
      softRst_q <= softResetReq;
      result_q <= softRst_q ? 12'h000 : (convDone ? convResult : result_q);
    end
  end

  // Frame bookkeeping
  // Counter restarts on every CS fall, so a cut frame leaves no stale count
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftIn_q <= 16'h0000;
      bitCnt_q <= 5'h00;
      readPending_q <= 1'b0;
      preempt_q <= 1'b0;
      frameIsFlags_q <= 1'b0;
    end else begin
      shiftIn_q <= link.sclkRise ? {shiftIn_q[14:0], link.sdiBit} : shiftIn_q;
      bitCnt_q <= link.frameStart ? 5'h00 : (link.sclkRise ? bitCnt_q + 5'h1 : bitCnt_q);
      readPending_q <= readPending_d;
      preempt_q <= preempt_d;
      frameIsFlags_q <= link.frameStart ? flagsSelected :
        (link.frameEnd ? 1'b0 : frameIsFlags_q);
    end
  end

  // Serial output and pin drive; enable low while driving
  // SDO comes from a flop so the pin never glitches inside a bit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftOut_q <= 16'h0000;
      sdo_q <= 1'b0;
      sdoOe_q <= 1'b1;
    end else begin
      shiftOut_q <= shiftOut_d;
      sdo_q <= shiftOut_d[15];
      sdoOe_q <= !(link.csActive || link.frameStart);
    end
  end

  assign sdoOut = sdo_q;
  assign sdoOe_n = sdoOe_q;
  assign flagsView = flags_q;
  assign resultView = result_q;
  assign multifunction_event_pin = evtPin_q;
endmodule : lavsr_status_reg
`default_nettype wire

// File: testbench/lavsr_spi_host.sv
/* SPI host model, mode 0, 200 ns serial clock.
   Assumes the bench calls xfer for each 16-bit frame. */
`timescale 1ns/1ps
`default_nettype none
module lavsr_spi_host (
  output var logic sclk,
  output var logic csN,
  output var logic sdi,
  input wire logic sdo
);
  // Idle pins, clock stands low between frames
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end
  // One frame, MSB first, data taken on each rise
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #7 csN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = tx[i];
      #100 sclk = 1'b1;
      rx[i] = sdo;
      #100 sclk = 1'b0;
    end
    #100 csN = 1'b1;
    sdi = ~sdi;
    // Whole frame spans 148 core clocks, keeping the phase to core_clk fixed
    #393;
  endtask : xfer
endmodule : lavsr_spi_host
`default_nettype wire

// File: testbench/lavsr_status_reg_props.sv
/* Assertions on the status register top ports.
   Assumes one core_clk domain with async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module lavsr_status_reg_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] variantSel,
  input wire logic csPin_n,
  input wire logic convDone,
  input wire logic [2:0] convChannel,
  input wire logic [11:0] convResult,
  input wire logic [71:0] lowLimits,
  input wire logic [71:0] highLimits,
  input wire logic softResetReq,
  input wire logic [15:0] flagsView,
  input wire logic [11:0] resultView,
  input wire logic multifunction_event_pin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Flag setting, keeping and clearing
  property p_over;
    convDone && csPin_n && !softResetReq && variantSel == 2'h2 &&
      convResult > {highLimits[convChannel * 9 +: 9], 3'h7} |-> ##[1:3] flagsView[{convChannel, 1'b0}];
  endproperty
  a_over: assert property (p_over) else $error("over flag not set");
  property p_under;
    convDone && csPin_n && !softResetReq && variantSel == 2'h2 &&
      convResult < {lowLimits[convChannel * 9 +: 9], 3'h0} |-> ##[1:3] flagsView[{convChannel, 1'b1}];
  endproperty
  a_under: assert property (p_under) else $error("under flag not set");
  property p_rise;
    (|(flagsView & ~$past(flagsView))) |-> $past(convDone) || $past(convDone, 2) ||
      $past(convDone, 3) || variantSel != $past(variantSel, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("flag set without event");
  property p_hold;
    (|($past(flagsView) & ~flagsView)) |-> !$past(csPin_n, 3) || $past(softResetReq) ||
      $past(softResetReq, 2) || $past(variantSel) != $past(variantSel, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_var2;
    (variantSel == 2'h0) [*3] |-> flagsView[15:4] == 12'h000;
  endproperty
  a_var2: assert property (p_var2) else $error("absent flag in 2ch");
  property p_var4;
    (variantSel == 2'h1) [*3] |-> flagsView[15:8] == 8'h00;
  endproperty
  a_var4: assert property (p_var4) else $error("absent flag in 4ch");
  property p_soft;
    softResetReq && !convDone |-> ##[1:2] flagsView == 16'h0000 && resultView == 12'h000;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset missed");
  property p_reset;
    $rose(reset_n) |-> flagsView == 16'h0000;
  endproperty
  a_reset: assert property (p_reset) else $error("flags not zero after reset");
  property p_pin;
    (|flagsView) |-> ##[0:1] multifunction_event_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("event pin low with flags");
endmodule : lavsr_status_reg_props
bind lavsr_status_reg lavsr_status_reg_props lavsr_status_reg_props_inst (
  .core_clk(core_clk), .reset_n(reset_n), .variantSel(variantSel), .csPin_n(csPin_n),
  .convDone(convDone), .convChannel(convChannel), .convResult(convResult),
  .lowLimits(lowLimits), .highLimits(highLimits), .softResetReq(softResetReq),
  .flagsView(flagsView), .resultView(resultView),
  .multifunction_event_pin(multifunction_event_pin));
`default_nettype wire

// File: testbench/lavsr_status_reg_tb.sv
/* Self-checking bench for the limit violation status register.
   Assumes the SPI host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module lavsr_status_reg_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] variantSel = 2'h2;
  logic convDone = 1'b0;
  logic [2:0] convChannel = 3'h0;
  logic [11:0] convResult = 12'h000;
  logic softResetReq = 1'b0;
  logic sclk, csN, sdi, sdoOut, sdoOe_n, evtPin;
  logic [15:0] flagsView, rx;
  logic [11:0] resultView;
  int n_errors = 0;
  int compares = 0;
  // Limits compare at 0x080 and 0x807
  wire logic [71:0] lowLimits = {8{9'h010}};
  wire logic [71:0] highLimits = {8{9'h100}};
  always #12.5 core_clk = ~core_clk;
  lavsr_spi_host lavsr_spi_host_inst (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdoOut));
  lavsr_status_reg lavsr_status_reg_inst (.core_clk(core_clk), .reset_n(reset_n),
    .variantSel(variantSel), .sclkPin(sclk), .csPin_n(csN), .sdiPin(sdi), .convDone(convDone),
    .convChannel(convChannel), .convResult(convResult), .lowLimits(lowLimits),
    .highLimits(highLimits), .softResetReq(softResetReq), .sdoOut(sdoOut), .sdoOe_n(sdoOe_n),
    .flagsView(flagsView), .resultView(resultView), .multifunction_event_pin(evtPin));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conv(input logic [2:0] ch, input logic [11:0] res);
    @(posedge core_clk) #1;
    convDone = 1'b1;
    convChannel = ch;
    convResult = res;
    @(posedge core_clk) #1;
    convDone = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : conv
  task automatic rd(output logic [15:0] data);
    lavsr_spi_host_inst.xfer(16'h1000, data);
    lavsr_spi_host_inst.xfer(16'h0000, data);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_all;
    chk("reset", flagsView, 16'h0000);
    conv(3'h2, 12'h807);
    conv(3'h2, 12'h080);
    chk("edge", flagsView, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      conv(c[2:0], 12'h808);
      chk("over", flagsView, 16'hffff >> (15 - 2 * c));
      conv(c[2:0], 12'h07f);
      chk("under", flagsView, 16'hffff >> (14 - 2 * c));
    end
    conv(3'h0, 12'h808);
    chk("repeat", flagsView, 16'hffff);
    chk("pinSet", {15'h0000, evtPin}, 16'h0001);
    rd(rx);
    chk("readOut", rx, 16'hffff);
    chk("readClear", flagsView, 16'h0000);
    chk("pinClear", {15'h0000, evtPin}, 16'h0000);
    chk("oeIdle", {15'h0000, sdoOe_n}, 16'h0001);
  endtask : t_all
  task automatic t_write_preempt;
    conv(3'h3, 12'h000);
    lavsr_spi_host_inst.xfer(16'h17ff, rx);
    chk("write", flagsView, 16'h0080);
    lavsr_spi_host_inst.xfer(16'h1000, rx);
    conv(3'h4, 12'h123);
    chk("result", {4'h0, resultView}, 16'h0123);
    lavsr_spi_host_inst.xfer(16'h0000, rx);
    chk("preData", rx, 16'h0123);
    chk("preKeep", flagsView, 16'h0080);
  endtask : t_write_preempt
  task automatic t_same;
    lavsr_spi_host_inst.xfer(16'h1000, rx);
    fork
      lavsr_spi_host_inst.xfer(16'h0000, rx);
      begin
        // Second SCLK rise; the core sees it two core clocks later
        repeat (2) @(posedge sclk);
        chk("oeDrive", {15'h0000, sdoOe_n}, 16'h0000);
        @(posedge core_clk);
        @(posedge core_clk) #1;
        // One conversion pulse exactly in the clear cycle
        convDone = 1'b1;
        convChannel = 3'h1;
        convResult = 12'h000;
        @(posedge core_clk) #1;
        convDone = 1'b0;
      end
    join
    chk("sameData", rx, 16'h0080);
    chk("sameKeep", flagsView, 16'h0008);
  endtask : t_same
  task automatic t_variant;
    @(posedge core_clk) #1 variantSel = 2'h1;
    conv(3'h5, 12'hfff);
    chk("var4", flagsView, 16'h0008);
    @(posedge core_clk) #1 variantSel = 2'h0;
    conv(3'h2, 12'h000);
    chk("var2", flagsView, 16'h0008);
    @(posedge core_clk) #1 softResetReq = 1'b1;
    @(posedge core_clk) #1 softResetReq = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("soft", flagsView, 16'h0000);
    chk("softRes", {4'h0, resultView}, 16'h0000);
  endtask : t_variant
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic end_of_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (12) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    t_all;
    t_write_preempt;
    t_same;
    t_variant;
    end_of_test;
  end
  initial begin
    #500000;
    n_errors++;
    end_of_test;
  end
endmodule : lavsr_status_reg_tb
`default_nettype wire
